// ===== stt_pkg.sv
// Package of register map, field layout and carrier types for the tuning bank.
package stt_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [6:0] OFF_PRESCALER = 7'h1c;
  localparam logic [6:0] OFF_PUMP_TEST = 7'h40;
  localparam logic [6:0] OFF_PUMP_VCO = 7'h41;
  localparam logic [6:0] OFF_BW_CONST = 7'h42;
  localparam logic [6:0] OFF_LOOP_BREAK = 7'h43;
  localparam logic [6:0] OFF_PUMP_STATUS = 7'h44;
  localparam logic [6:0] OFF_CAL_STATUS = 7'h45;
  localparam logic [6:0] OFF_OSC_STATUS = 7'h46;

  localparam int PRE_SWING_POS = 6;
  localparam int PRE_CURRENT_POS = 4;
  localparam int BYPASS_R_POS = 3;
  localparam int DISCONNECT_C_POS = 2;
  localparam int TP1_POS = 7;
  localparam int TP2_POS = 6;
  localparam int PUMP_FORCE_POS = 5;
  localparam int PUMP_DIS_POS = 5;
  localparam int OSC_FORCE_POS = 4;
  localparam int LOOP_BREAK_POS = 4;

  localparam logic [1:0] RST_PRE_SWING = 2'h0;
  localparam logic [1:0] RST_PRE_CURRENT = 2'h0;
  localparam logic [4:0] RST_PUMP_VALUE = 5'h10;
  localparam logic [3:0] RST_OSC_VALUE = 4'h8;
  localparam logic [5:0] RST_BW_CONST = 6'h25;
  localparam logic [3:0] RST_CAL_OPEN = 4'h4;

  typedef struct packed {
    logic [1:0] pre_swing;
    logic [1:0] pre_current;
    logic bypass_r;
    logic disconnect_c;
    logic testpoint_one_route;
    logic testpoint_two_route;
    logic pump_current_force;
    logic [4:0] pump_current_forced_value;
    logic pump_pulse_disable;
    logic osc_array_force;
    logic [3:0] osc_array_forced_value;
    logic [5:0] loop_bandwidth_const;
    logic loop_break;
    logic [3:0] cal_dac_open;
  } stt_cfg_type;

  typedef struct packed {
    logic [4:0] pump_current;
    logic [3:0] cal_dac;
    logic [3:0] osc_array;
  } stt_cal_type;

  typedef struct packed {
    logic [1:0] pre_swing;
    logic [1:0] pre_current;
    logic bypass_r;
    logic disconnect_c;
    logic tp_one;
    logic tp_two;
    logic pump_up;
    logic pump_down;
    logic [5:0] loop_bandwidth_const;
    logic loop_open;
    stt_cal_type applied;
  } stt_ana_type;
endpackage : stt_pkg

// ===== stt_apply_mux.sv
// Override selection between calibrated and software values.
`timescale 1ns/10ps
`default_nettype none
module stt_apply_mux (
  input wire stt_pkg::stt_cfg_type cfg_i,
  input wire stt_pkg::stt_cal_type cal_i,
  input wire logic up_i,
  input wire logic down_i,
  output logic up_o,
  output logic down_o,
  output stt_pkg::stt_cal_type applied_o
);
  always_comb begin
    applied_o.pump_current = cfg_i.pump_current_force ?
      cfg_i.pump_current_forced_value : cal_i.pump_current;
    applied_o.osc_array = cfg_i.osc_array_force ?
      cfg_i.osc_array_forced_value : cal_i.osc_array;
    applied_o.cal_dac = cfg_i.loop_break ?
      cfg_i.cal_dac_open : cal_i.cal_dac;
    up_o = up_i & ~cfg_i.pump_pulse_disable;
    down_o = down_i & ~cfg_i.pump_pulse_disable;
  end
endmodule : stt_apply_mux
`default_nettype wire

// ===== stt_regs.sv
// Synthesizer tuning and test register bank with registered analog controls.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module stt_regs (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [6:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire stt_pkg::stt_cal_type cal_i,
  input wire logic pump_up_i,
  input wire logic pump_down_i,
  output logic [7:0] rdata_o,
  output stt_pkg::stt_ana_type ana_o
);
  typedef struct packed {
    stt_pkg::stt_cfg_type cfg;
    logic [7:0] rdata;
    stt_pkg::stt_ana_type ana;
  } stt_state_type;

  stt_state_type state;
  stt_state_type next_state;
  stt_pkg::stt_cal_type applied;
  logic gated_up;
  logic gated_down;

  stt_apply_mux u_mux (
    .cfg_i(state.cfg),
    .cal_i(cal_i),
    .up_i(pump_up_i),
    .down_i(pump_down_i),
    .up_o(gated_up),
    .down_o(gated_down),
    .applied_o(applied)
  );

  function automatic stt_pkg::stt_cfg_type cfg_reset();
    stt_pkg::stt_cfg_type c;
    c = '0;
    c.pre_swing = stt_pkg::RST_PRE_SWING;
    c.pre_current = stt_pkg::RST_PRE_CURRENT;
    c.pump_current_forced_value = stt_pkg::RST_PUMP_VALUE;
    c.osc_array_forced_value = stt_pkg::RST_OSC_VALUE;
    c.loop_bandwidth_const = stt_pkg::RST_BW_CONST;
    c.cal_dac_open = stt_pkg::RST_CAL_OPEN;
    return c;
  endfunction : cfg_reset

  always_comb begin
    next_state = state;
    if (wr_i) begin
      case (addr_i)
        stt_pkg::OFF_PRESCALER: begin
          next_state.cfg.pre_swing =
            wdata_i[stt_pkg::PRE_SWING_POS +: 2];
          next_state.cfg.pre_current =
            wdata_i[stt_pkg::PRE_CURRENT_POS +: 2];
          next_state.cfg.bypass_r = wdata_i[stt_pkg::BYPASS_R_POS];
          next_state.cfg.disconnect_c =
            wdata_i[stt_pkg::DISCONNECT_C_POS];
        end
        stt_pkg::OFF_PUMP_TEST: begin
          next_state.cfg.testpoint_one_route =
            wdata_i[stt_pkg::TP1_POS];
          next_state.cfg.testpoint_two_route =
            wdata_i[stt_pkg::TP2_POS];
          next_state.cfg.pump_current_force =
            wdata_i[stt_pkg::PUMP_FORCE_POS];
          next_state.cfg.pump_current_forced_value = wdata_i[4:0];
        end
        stt_pkg::OFF_PUMP_VCO: begin
          next_state.cfg.pump_pulse_disable =
            wdata_i[stt_pkg::PUMP_DIS_POS];
          next_state.cfg.osc_array_force =
            wdata_i[stt_pkg::OSC_FORCE_POS];
          next_state.cfg.osc_array_forced_value = wdata_i[3:0];
        end
        stt_pkg::OFF_BW_CONST: begin
          next_state.cfg.loop_bandwidth_const = wdata_i[5:0];
        end
        stt_pkg::OFF_LOOP_BREAK: begin
          next_state.cfg.loop_break =
            wdata_i[stt_pkg::LOOP_BREAK_POS];
          next_state.cfg.cal_dac_open = wdata_i[3:0];
        end
        default: begin
          next_state.cfg = state.cfg;
        end
      endcase
    end
    // Read data stand only in the cycle after the strobe; zero otherwise.
    next_state.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        stt_pkg::OFF_PRESCALER: begin
          next_state.rdata = {state.cfg.pre_swing, state.cfg.pre_current,
            state.cfg.bypass_r, state.cfg.disconnect_c, 2'h0};
        end
        stt_pkg::OFF_PUMP_TEST: begin
          next_state.rdata = {state.cfg.testpoint_one_route,
            state.cfg.testpoint_two_route, state.cfg.pump_current_force,
            state.cfg.pump_current_forced_value};
        end
        stt_pkg::OFF_PUMP_VCO: begin
          next_state.rdata = {2'h0, state.cfg.pump_pulse_disable,
            state.cfg.osc_array_force,
            state.cfg.osc_array_forced_value};
        end
        stt_pkg::OFF_BW_CONST: begin
          next_state.rdata = {2'h0, state.cfg.loop_bandwidth_const};
        end
        stt_pkg::OFF_LOOP_BREAK: begin
          next_state.rdata = {3'h0, state.cfg.loop_break,
            state.cfg.cal_dac_open};
        end
        stt_pkg::OFF_PUMP_STATUS: begin
          next_state.rdata = {3'h0, state.ana.applied.pump_current};
        end
        stt_pkg::OFF_CAL_STATUS: begin
          next_state.rdata = {4'h0, state.ana.applied.cal_dac};
        end
        stt_pkg::OFF_OSC_STATUS: begin
          next_state.rdata = {4'h0, state.ana.applied.osc_array};
        end
        default: begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
    next_state.ana.pre_swing = state.cfg.pre_swing;
    next_state.ana.pre_current = state.cfg.pre_current;
    next_state.ana.bypass_r = state.cfg.bypass_r;
    next_state.ana.disconnect_c = state.cfg.disconnect_c;
    // A low select grounds the test-point path to the pump pin.
    next_state.ana.tp_one = state.cfg.testpoint_one_route;
    next_state.ana.tp_two = state.cfg.testpoint_two_route;
    next_state.ana.pump_up = gated_up;
    next_state.ana.pump_down = gated_down;
    next_state.ana.loop_bandwidth_const = state.cfg.loop_bandwidth_const;
    next_state.ana.loop_open = state.cfg.loop_break;
    next_state.ana.applied = applied;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state.cfg <= cfg_reset();
      state.rdata <= 8'h00;
      state.ana <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign rdata_o = state.rdata;
  assign ana_o = state.ana;

  a_pump_force_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state.cfg.pump_current_force |=> ana_o.applied.pump_current ==
    $past(state.cfg.pump_current_forced_value))
    else $error("Forced pump current not applied.");

  a_pump_cal_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !state.cfg.pump_current_force |=>
    ana_o.applied.pump_current == $past(cal_i.pump_current))
    else $error("Calibrated pump current not applied.");

  a_pulse_disable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state.cfg.pump_pulse_disable |=>
    !ana_o.pump_up && !ana_o.pump_down)
    else $error("Pump pulse passed while disabled.");

  a_osc_force_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state.cfg.osc_array_force |=> ana_o.applied.osc_array ==
    $past(state.cfg.osc_array_forced_value))
    else $error("Forced oscillator array not applied.");

  a_loop_open_dac: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state.cfg.loop_break |=> ana_o.loop_open &&
    ana_o.applied.cal_dac == $past(state.cfg.cal_dac_open))
    else $error("Open loop did not apply the override DAC value.");

  a_status_read: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && addr_i == stt_pkg::OFF_PUMP_STATUS |=>
    rdata_o == {3'h0, $past(ana_o.applied.pump_current)})
    else $error("Pump status read mismatch.");

  a_unused_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && addr_i == stt_pkg::OFF_PRESCALER |=>
    rdata_o[1:0] == 2'h0)
    else $error("Unused prescaler bits read nonzero.");

  a_bw_write_back: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_BW_CONST ##1
    ce_i && rd_i && addr_i == stt_pkg::OFF_BW_CONST |=>
    rdata_o == {2'h0, $past(wdata_i[5:0], 2)})
    else $error("Bandwidth constant write did not read back.");

  a_swing_reset: assert property (
    @(posedge clk_i)
    !rst_n_i |=> state.cfg.pre_swing == 2'h0 &&
    state.cfg.pre_current == 2'h0)
    else $error("Prescaler fields not reset to zero.");

  a_route_follow: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_TEST ##1 ce_i |=>
    ana_o.tp_one == $past(wdata_i[7], 2) &&
    ana_o.tp_two == $past(wdata_i[6], 2))
    else $error("Test point routing did not follow the write.");

  // Each field must take exactly its own bits of the write data.
  a_swing_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PRESCALER |=>
    state.cfg.pre_swing == $past(wdata_i[7:6]))
    else $error("Prescaler swing write mismatch.");

  a_current_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PRESCALER |=>
    state.cfg.pre_current == $past(wdata_i[5:4]))
    else $error("Prescaler current write mismatch.");

  a_bypass_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PRESCALER |=>
    state.cfg.bypass_r == $past(wdata_i[3]))
    else $error("Resistor bypass write mismatch.");

  a_cap_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PRESCALER |=>
    state.cfg.disconnect_c == $past(wdata_i[2]))
    else $error("Capacitor disconnect write mismatch.");

  a_tp_one_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_TEST |=>
    state.cfg.testpoint_one_route == $past(wdata_i[7]))
    else $error("Test point one write mismatch.");

  a_tp_two_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_TEST |=>
    state.cfg.testpoint_two_route == $past(wdata_i[6]))
    else $error("Test point two write mismatch.");

  a_force_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_TEST |=>
    state.cfg.pump_current_force == $past(wdata_i[5]))
    else $error("Pump force write mismatch.");

  a_pump_value_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_TEST |=>
    state.cfg.pump_current_forced_value == $past(wdata_i[4:0]))
    else $error("Forced pump value write mismatch.");

  a_disable_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_VCO |=>
    state.cfg.pump_pulse_disable == $past(wdata_i[5]))
    else $error("Pump disable write mismatch.");

  a_osc_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_PUMP_VCO |=>
    state.cfg.osc_array_force == $past(wdata_i[4]) &&
    state.cfg.osc_array_forced_value == $past(wdata_i[3:0]))
    else $error("Oscillator override write mismatch.");

  a_bw_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_BW_CONST |=>
    state.cfg.loop_bandwidth_const == $past(wdata_i[5:0]))
    else $error("Bandwidth constant write mismatch.");

  a_break_write: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && wr_i && addr_i == stt_pkg::OFF_LOOP_BREAK |=>
    state.cfg.loop_break == $past(wdata_i[4]) &&
    state.cfg.cal_dac_open == $past(wdata_i[3:0]))
    else $error("Loop break write mismatch.");

  // Outputs follow the registers and the pump and calibration inputs one stage later.
  a_pulse_pass: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !state.cfg.pump_pulse_disable |=>
    ana_o.pump_up == $past(pump_up_i) && ana_o.pump_down == $past(pump_down_i))
    else $error("Pump pulse blocked while enabled.");

  a_osc_cal_sel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !state.cfg.osc_array_force |=>
    ana_o.applied.osc_array == $past(cal_i.osc_array))
    else $error("Calibrated oscillator array not applied.");

  a_loop_closed: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !state.cfg.loop_break |=> !ana_o.loop_open &&
    ana_o.applied.cal_dac == $past(cal_i.cal_dac))
    else $error("Closed loop did not apply the calibrated DAC value.");

  a_bw_output: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=>
    ana_o.loop_bandwidth_const == $past(state.cfg.loop_bandwidth_const))
    else $error("Bandwidth output does not follow the register.");

  a_bypass_output: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> ana_o.bypass_r == $past(state.cfg.bypass_r))
    else $error("Bypass output does not follow the register.");

  a_cap_output: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i |=> ana_o.disconnect_c == $past(state.cfg.disconnect_c))
    else $error("Disconnect output does not follow the register.");

  a_vco_unused: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && addr_i == stt_pkg::OFF_PUMP_VCO |=>
    rdata_o[7:6] == 2'h0)
    else $error("Unused pump disable bits read nonzero.");

  a_break_unused: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && rd_i && addr_i == stt_pkg::OFF_LOOP_BREAK |=>
    rdata_o[7:5] == 3'h0)
    else $error("Unused loop break bits read nonzero.");
endmodule : stt_regs
`default_nettype wire

// ===== stt_regs_tb.sv
// Self-checking testbench for the synthesizer tuning register bank.
`timescale 1ns/10ps
`default_nettype none
module stt_regs_tb;
  localparam logic [12:0] CAL = {5'h0a, 4'h3, 4'h5};
  logic clk_i, rst_n_i, ce_i, wr_i, rd_i, pump_up_i, pump_down_i;
  logic [6:0] addr_i;
  logic [7:0] wdata_i, rdata_o;
  stt_pkg::stt_cal_type cal_i;
  stt_pkg::stt_ana_type ana_o;
  int failures;
  int tests_run;
  logic [6:0] offs [5];
  logic [7:0] masks [5];

  stt_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .cal_i(cal_i), .pump_up_i(pump_up_i), .pump_down_i(pump_down_i),
    .rdata_o(rdata_o), .ana_o(ana_o));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the read edge, so sample there.
  task automatic rd_chk(input string what, input logic [6:0] a,
                        input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, rdata_o});
  endtask : rd_chk

  // Outputs trail the register write by one extra stage.
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  initial begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 7'h00;
    wdata_i = 8'h00;
    cal_i = CAL;
    pump_up_i = 1'b0;
    pump_down_i = 1'b0;
    failures = 0;
    tests_run = 0;
    offs = '{stt_pkg::OFF_PRESCALER, stt_pkg::OFF_PUMP_TEST,
             stt_pkg::OFF_PUMP_VCO, stt_pkg::OFF_BW_CONST,
             stt_pkg::OFF_LOOP_BREAK};
    masks = '{8'hfc, 8'hff, 8'h3f, 8'h3f, 8'h1f};
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    rd_chk("prescaler reset", offs[0], 8'h00);
    rd_chk("pump test reset", offs[1], 8'h10);
    rd_chk("pump vco reset", offs[2], 8'h08);
    rd_chk("bandwidth reset", offs[3], 8'h25);
    rd_chk("loop break reset", offs[4], 8'h04);
    chk("bandwidth out", 16'h0025, 16'(ana_o.loop_bandwidth_const));
    chk("applied reset", 16'(CAL), 16'(ana_o.applied));
    chk("loop open reset", 16'h0000, 16'(ana_o.loop_open));
    @(posedge clk_i);
    #1;
    chk("read data idle", 16'h0000, {8'h00, rdata_o});
    // Every field forced on: overrides, loop break and pulse blanking.
    for (int i = 0; i < 5; i++) begin
      wr(offs[i], 8'hff);
      rd_chk("all ones", offs[i], masks[i]);
    end
    pump_up_i <= 1'b1;
    pump_down_i <= 1'b1;
    settle();
    chk("forced applied", 16'h1fff, 16'(ana_o.applied));
    chk("blanked", 16'h0000, 16'({ana_o.pump_up, ana_o.pump_down}));
    chk("tp both", 16'h0003, 16'({ana_o.tp_one, ana_o.tp_two}));
    chk("loop open", 16'h0001, 16'(ana_o.loop_open));
    chk("bandwidth fast", 16'h003f, 16'(ana_o.loop_bandwidth_const));
    rd_chk("pump status forced", stt_pkg::OFF_PUMP_STATUS, 8'h1f);
    rd_chk("cal status forced", stt_pkg::OFF_CAL_STATUS, 8'h0f);
    rd_chk("osc status forced", stt_pkg::OFF_OSC_STATUS, 8'h0f);
    // Back to calibrated values, with test point one only.
    wr(offs[1], 8'h80);
    wr(offs[2], 8'h00);
    wr(offs[4], 8'h00);
    settle();
    chk("cal applied", 16'(CAL), 16'(ana_o.applied));
    chk("pulses", 16'h0003, 16'({ana_o.pump_up, ana_o.pump_down}));
    chk("tp one", 16'h0002, 16'({ana_o.tp_one, ana_o.tp_two}));
    chk("loop closed", 16'h0000, 16'(ana_o.loop_open));
    wr(offs[1], 8'h40);
    settle();
    chk("tp two", 16'h0001, 16'({ana_o.tp_one, ana_o.tp_two}));
    rd_chk("pump status cal", stt_pkg::OFF_PUMP_STATUS, 8'h0a);
    rd_chk("cal status cal", stt_pkg::OFF_CAL_STATUS, 8'h03);
    rd_chk("osc status cal", stt_pkg::OFF_OSC_STATUS, 8'h05);
    // Status is read-only and unmapped places hold nothing.
    wr(stt_pkg::OFF_PUMP_STATUS, 8'hff);
    wr(7'h7f, 8'hff);
    rd_chk("status after write", stt_pkg::OFF_PUMP_STATUS, 8'h0a);
    rd_chk("unmapped read", 7'h7f, 8'h00);
    // Each swing and current code, with the filter bits varied alongside.
    for (int c = 0; c < 4; c++) begin
      wr(offs[0], {2'(c), 2'(3 - c), 2'(c), 2'h3});
      rd_chk("prescaler code", offs[0],
        {2'(c), 2'(3 - c), 2'(c), 2'h0});
      settle();
      chk("swing", 16'(c), 16'(ana_o.pre_swing));
      chk("current", 16'(3 - c), 16'(ana_o.pre_current));
      chk("bypass", 16'(c[1]), 16'(ana_o.bypass_r));
      chk("disconnect", 16'(c[0]), 16'(ana_o.disconnect_c));
    end
    // Write and read of one place with no gap between the strobes.
    @(posedge clk_i);
    addr_i <= offs[3];
    wdata_i <= 8'h2a;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("write then read", 16'h002a, {8'h00, rdata_o});
    // A write while the clock enable is low must be lost.
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(offs[3], 8'h11);
    ce_i <= 1'b1;
    rd_chk("frozen write", offs[3], 8'h2a);
    // A second reset in mid-run, taken with the enable low.
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    ce_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ce_i <= 1'b1;
    rd_chk("bandwidth again", offs[3], 8'h25);
    rd_chk("prescaler again", offs[0], 8'h00);
    tally_and_finish();
  end
endmodule : stt_regs_tb
`default_nettype wire
